// File: design/bus_cycle_sequencer.sv
// bus cycle sequencer: address, read/write level and data for every E-cycle
// ----------------------------------------------------------------
// Notes on behaviour
// - every cycle drives defined address, level, data
// - same mode and kind share one sequence, except inherent ops and test
// - cycle count follows the instruction timing table
// - internal reads reach the bus only in mode 0
// - 16-bit values: high byte at the lower address, read or stored first, pushed last
// - immediate 16-bit loads: opcode, high, low
// - immediate 16-bit compares end with dummy cycle
// - direct 16-bit stores write high then low
// - direct subroutine call: five cycles, two pushes
// - extended subroutine call: six cycles, two pushes
// - extended jump: three read cycles
// - extended accumulator store writes in cycle four
// - extended read-modify-write: read, dummy, write back
// - test instruction replaces final write by dummy
// - extended 16-bit compares: two reads, dummy
// - indexed 8-bit: offset, dummy, index plus offset
// - indexed 16-bit: high at ea, low after
// - indexed subroutine call: offset, dummy, read, two pushes
// - extended 16-bit loads read high then low
// - extended call reads target before pushing
// ----------------------------------------------------------------
module bus_cycle_sequencer #(
  parameter logic [15:0] RESET_PC = seq_pkg::RESET_PC_DEF
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        mode0_i,
  input  wire logic        internal_hit_i,
  input  wire logic [7:0]  internal_data_i,
  input  wire logic [7:0]  acc_a_i,
  input  wire logic [7:0]  acc_b_i,
  input  wire logic [15:0] index_i,
  input  wire logic [15:0] stack_i,
  input  wire logic [7:0]  ccr_i,
  input  wire logic [7:0]  new_operand_i,
  input  wire logic        branch_taken_i,
  output logic             e_clk_o,
  output logic [15:0]      addr_o,
  output logic             rw_o,
  output logic [7:0]       data_o,
  output logic             data_oe_n_o,
  output logic [7:0]       rd_data_o,
  output logic             rd_strobe_o,
  output logic [7:0]       opcode_o,
  output logic             instr_done_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]      div_reg;
  logic            e_tick;
  logic [3:0]      cyc_reg;
  logic [7:0]      op_reg;
  logic [15:0]     pc_reg;
  logic [15:0]     ea_reg;
  seq_pkg::role_t  role_reg;
  logic [15:0]     addr_reg;
  logic            rw_reg;
  logic [7:0]      wdata_reg;
  logic            dummy_reg;

  // ----------------------------------------------------------------
  // decode of the current instruction
  // ----------------------------------------------------------------
  function automatic seq_pkg::mode_t decode_mode(input logic [7:0] op);
    if (op[7:4] == 4'h2) decode_mode = seq_pkg::M_REL;
    else if (op < 8'h60) decode_mode = seq_pkg::M_INH;
    else if (op[7:4] == 4'h6) decode_mode = seq_pkg::M_IDX;
    else if (op[7:4] == 4'h7) decode_mode = seq_pkg::M_EXT;
    else begin
      case (op[5:4])
        2'b00:   decode_mode = seq_pkg::M_IMM;
        2'b01:   decode_mode = seq_pkg::M_DIR;
        2'b10:   decode_mode = seq_pkg::M_IDX;
        default: decode_mode = seq_pkg::M_EXT;
      endcase
    end
  endfunction

  // opcodes are grouped by bus behaviour, not by arithmetic
  function automatic seq_pkg::kind_t decode_kind(input logic [7:0] op);
    if (op[7:4] == 4'h2) decode_kind = seq_pkg::K_REL;
    else if (op < 8'h60) decode_kind = seq_pkg::K_INH;
    else if (!op[7]) decode_kind = (op[3:0] == 4'he) ? seq_pkg::K_JMP : seq_pkg::K_RMW;
    else begin
      case (op[3:0])
        4'h3:    decode_kind = seq_pkg::K_CMP16;
        4'hc:    decode_kind = op[6] ? seq_pkg::K_LD16 : seq_pkg::K_CMP16;
        4'hd:    decode_kind = op[6] ? seq_pkg::K_ST16
                             : (op[5:4] == 2'b00) ? seq_pkg::K_BSR : seq_pkg::K_JSR;
        4'he:    decode_kind = seq_pkg::K_LD16;
        4'hf:    decode_kind = seq_pkg::K_ST16;
        4'h7:    decode_kind = seq_pkg::K_ST8;
        default: decode_kind = seq_pkg::K_RD8;
      endcase
    end
  endfunction

  // operand cycles after the address phase
  function automatic logic [3:0] kind_cycles(input seq_pkg::kind_t k);
    case (k)
      seq_pkg::K_RD8, seq_pkg::K_ST8:   kind_cycles = 4'h1;
      seq_pkg::K_LD16, seq_pkg::K_ST16: kind_cycles = 4'h2;
      seq_pkg::K_JMP:                   kind_cycles = 4'h0;
      default:                          kind_cycles = 4'h3;
    endcase
  endfunction

  logic [7:0]     op_cur;
  seq_pkg::mode_t mode_cur;
  seq_pkg::kind_t kind_cur;
  logic [3:0]     s_cur;
  logic [3:0]     last_cur;
  logic [15:0]    bytes_cur;
  logic           is_tst;
  logic [15:0]    r16;
  logic [7:0]     r8;

  // the opcode is used while it is still on the bus in cycle 1
  assign op_cur   = (cyc_reg == seq_pkg::CYC_FIRST) ? data_i : op_reg;
  assign mode_cur = decode_mode(op_cur);
  assign kind_cur = decode_kind(op_cur);
  assign is_tst   = (kind_cur == seq_pkg::K_RMW) && (op_cur[3:0] == 4'hd);
  assign s_cur    = (kind_cur == seq_pkg::K_BSR) ? seq_pkg::S_FAR
                  : (mode_cur == seq_pkg::M_IMM) ? seq_pkg::S_IMM
                  : (mode_cur == seq_pkg::M_DIR) ? seq_pkg::S_DIR : seq_pkg::S_FAR;
  assign last_cur = (kind_cur == seq_pkg::K_INH) ? seq_pkg::inh_len(op_cur)
                  : (kind_cur == seq_pkg::K_REL) ? seq_pkg::CYC_REL
                  : 4'(s_cur + kind_cycles(kind_cur) - 4'h1);
  assign bytes_cur = (mode_cur == seq_pkg::M_INH) ? 16'h1
                   : (mode_cur == seq_pkg::M_EXT) ? 16'h3
                   : (mode_cur == seq_pkg::M_IMM && (kind_cur == seq_pkg::K_LD16
                      || kind_cur == seq_pkg::K_CMP16)) ? 16'h3 : 16'h2;
  // store sources: double accumulator, index or stack pointer
  assign r16 = (op_cur[3:0] == 4'hd) ? {acc_a_i, acc_b_i} : op_cur[6] ? index_i : stack_i;
  assign r8  = op_cur[6] ? acc_b_i : acc_a_i;

  // ----------------------------------------------------------------
  // cycle counter, effective address and next program counter
  // ----------------------------------------------------------------
  logic [3:0]  cyc_next;
  logic [3:0]  k;
  logic [3:0]  pk;
  logic [15:0] ea_next;
  logic [15:0] ret_addr;
  logic        is_last;
  logic        to_target;
  logic [15:0] pc_next;

  assign e_tick   = (div_reg == seq_pkg::E_DIV_LAST);
  assign is_last  = (cyc_reg == last_cur);
  assign cyc_next = is_last ? seq_pkg::CYC_FIRST : 4'(cyc_reg + 4'h1);
  assign k        = 4'(cyc_next - s_cur);
  assign pk       = 4'(cyc_next - 4'h3);
  assign ret_addr = 16'(pc_reg + bytes_cur);

  // capture of address bytes read in the cycle now ending
  assign ea_next = (role_reg == seq_pkg::R_OP)  ? 16'(pc_reg + 16'h1)
                 : (role_reg == seq_pkg::R_AHI) ? {data_i, ea_reg[7:0]}
                 : (role_reg == seq_pkg::R_ALO) ? {ea_reg[15:8], data_i}
                 : (role_reg == seq_pkg::R_DIR) ? {8'h00, data_i}
                 : (role_reg == seq_pkg::R_OFF) ? 16'(index_i + {8'h00, data_i})
                 : (role_reg == seq_pkg::R_REL) ? 16'(pc_reg + 16'h2 + {{8{data_i[7]}}, data_i})
                 : ea_reg;

  assign to_target = (kind_cur == seq_pkg::K_JMP) || (kind_cur == seq_pkg::K_JSR)
                  || (kind_cur == seq_pkg::K_BSR)
                  || (kind_cur == seq_pkg::K_REL && branch_taken_i)
                  || (op_cur == seq_pkg::OP_RTS) || (op_cur == seq_pkg::OP_RTI)
                  || (op_cur == seq_pkg::OP_SWI);
  assign pc_next = to_target ? ea_next : ret_addr;

  // ----------------------------------------------------------------
  // next bus cycle: address, level, write data, capture role
  // ----------------------------------------------------------------
  logic [15:0]    nx_addr;
  logic           nx_rw;
  logic [7:0]     nx_wdata;
  seq_pkg::role_t nx_role;
  logic           nx_dummy;

  // unlisted cycles fall to a dummy read, so every cycle is defined
  always_comb begin
    nx_addr  = seq_pkg::ADDR_DUMMY;
    nx_rw    = 1'b1;
    nx_wdata = 8'h00;
    nx_role  = seq_pkg::R_NONE;
    nx_dummy = 1'b1;
    if (cyc_next == seq_pkg::CYC_FIRST) begin
      nx_addr  = pc_next;
      nx_role  = seq_pkg::R_OP;
      nx_dummy = 1'b0;
    end else if (cyc_next == 4'h2 && s_cur != seq_pkg::S_IMM) begin
      nx_addr  = 16'(pc_reg + 16'h1);
      nx_dummy = 1'b0;
      case (mode_cur)
        seq_pkg::M_DIR: nx_role = seq_pkg::R_DIR;
        seq_pkg::M_IDX: nx_role = seq_pkg::R_OFF;
        seq_pkg::M_EXT: nx_role = seq_pkg::R_AHI;
        seq_pkg::M_INH: nx_role = seq_pkg::R_NONE;
        default:        nx_role = seq_pkg::R_REL;
      endcase
    end else if (kind_cur == seq_pkg::K_INH) begin
      if (op_cur == seq_pkg::OP_SWI || op_cur == seq_pkg::OP_WAI) begin
        if (cyc_next <= 4'ha) begin
          nx_addr  = 16'(stack_i - {12'h000, pk});
          nx_rw    = (cyc_next > seq_pkg::CYC_WAI);
          nx_dummy = 1'b0;
          case (pk)
            4'h0:    nx_wdata = ret_addr[7:0];
            4'h1:    nx_wdata = ret_addr[15:8];
            4'h2:    nx_wdata = index_i[7:0];
            4'h3:    nx_wdata = index_i[15:8];
            4'h4:    nx_wdata = acc_a_i;
            4'h5:    nx_wdata = acc_b_i;
            4'h6:    nx_wdata = ccr_i;
            default: nx_wdata = 8'h00;
          endcase
        end else begin
          nx_addr  = (cyc_next == seq_pkg::CYC_SWI) ? seq_pkg::VEC_SWI_LO : seq_pkg::VEC_SWI_HI;
          nx_role  = (cyc_next == seq_pkg::CYC_SWI) ? seq_pkg::R_ALO : seq_pkg::R_AHI;
          nx_dummy = 1'b0;
        end
      end else if (op_cur == seq_pkg::OP_RTI || op_cur == seq_pkg::OP_RTS) begin
        nx_addr  = 16'(stack_i + {12'h000, pk});
        nx_dummy = 1'b0;
        nx_role  = (cyc_next == last_cur) ? seq_pkg::R_ALO
                 : (cyc_next == 4'(last_cur - 4'h1)) ? seq_pkg::R_AHI
                 : (cyc_next == 4'h3) ? seq_pkg::R_NONE : seq_pkg::R_DATA;
      end
    end else if (mode_cur == seq_pkg::M_EXT && cyc_next == 4'h3) begin
      nx_addr  = 16'(pc_reg + 16'h2);
      nx_role  = seq_pkg::R_ALO;
      nx_dummy = 1'b0;
    end else if (cyc_next >= s_cur && kind_cur != seq_pkg::K_REL) begin
      nx_dummy = 1'b0;
      case (kind_cur)
        seq_pkg::K_RD8: begin
          nx_addr = ea_next;
          nx_role = seq_pkg::R_DATA;
        end
        seq_pkg::K_ST8: begin
          nx_addr  = ea_next;
          nx_rw    = 1'b0;
          nx_wdata = r8;
        end
        seq_pkg::K_LD16: begin
          nx_addr = 16'(ea_next + {15'h0000, k[0]});
          nx_role = seq_pkg::R_DATA;
        end
        seq_pkg::K_ST16: begin
          nx_addr  = 16'(ea_next + {15'h0000, k[0]});
          nx_rw    = 1'b0;
          nx_wdata = k[0] ? r16[7:0] : r16[15:8];
        end
        seq_pkg::K_CMP16: begin
          nx_addr  = (k < 4'h2) ? 16'(ea_next + {15'h0000, k[0]}) : seq_pkg::ADDR_DUMMY;
          nx_role  = (k < 4'h2) ? seq_pkg::R_DATA : seq_pkg::R_NONE;
          nx_dummy = (k >= 4'h2);
        end
        seq_pkg::K_RMW: begin
          // the test instruction only reads, so its last cycle stays a dummy
          nx_addr  = (k == 4'h1 || is_tst && k == 4'h2) ? seq_pkg::ADDR_DUMMY : ea_next;
          nx_rw    = !(k == 4'h2 && !is_tst);
          nx_wdata = new_operand_i;
          nx_role  = (k == 4'h0) ? seq_pkg::R_DATA : seq_pkg::R_NONE;
          nx_dummy = (k == 4'h1) || (is_tst && k == 4'h2);
        end
        seq_pkg::K_JSR, seq_pkg::K_BSR: begin
          // target opcode read comes before the return address pushes
          nx_addr  = (k == 4'h0) ? ea_next
                   : (k == 4'h1) ? stack_i : 16'(stack_i - 16'h1);
          nx_rw    = (k == 4'h0);
          nx_wdata = (k == 4'h1) ? ret_addr[7:0] : ret_addr[15:8];
        end
        default: begin
          nx_dummy = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // E-clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      div_reg <= 8'h00;
      e_clk_o <= 1'b0;
    end else begin
      div_reg <= e_tick ? 8'h00 : 8'(div_reg + 8'h01);
      e_clk_o <= (div_reg >= seq_pkg::E_DIV_HALF);
    end
  end

  // bus cycle registers advance once per E-cycle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_reg   <= seq_pkg::CYC_FIRST;
      op_reg    <= 8'h00;
      pc_reg    <= RESET_PC;
      ea_reg    <= 16'h0000;
      role_reg  <= seq_pkg::R_OP;
      addr_reg  <= RESET_PC;
      rw_reg    <= 1'b1;
      wdata_reg <= 8'h00;
      dummy_reg <= 1'b0;
    end else if (e_tick) begin
      cyc_reg   <= cyc_next;
      op_reg    <= op_cur;
      pc_reg    <= is_last ? pc_next : pc_reg;
      ea_reg    <= ea_next;
      role_reg  <= nx_role;
      addr_reg  <= nx_addr;
      rw_reg    <= nx_rw;
      wdata_reg <= nx_wdata;
      dummy_reg <= nx_dummy;
    end
  end

  // core-facing strobes and the data bus drive
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o    <= 8'h00;
      rd_strobe_o  <= 1'b0;
      opcode_o     <= 8'h00;
      instr_done_o <= 1'b0;
      data_o       <= 8'h00;
      data_oe_n_o  <= 1'b1;
    end else begin
      rd_strobe_o  <= e_tick && (role_reg == seq_pkg::R_DATA);
      rd_data_o    <= (e_tick && role_reg == seq_pkg::R_DATA) ? data_i : rd_data_o;
      opcode_o     <= (e_tick && cyc_reg == seq_pkg::CYC_FIRST) ? data_i : opcode_o;
      instr_done_o <= e_tick && is_last;
      // internal reads stay off the pins unless mode 0 mirrors them
      data_o       <= rw_reg ? internal_data_i : wdata_reg;
      data_oe_n_o  <= !(!rw_reg || (internal_hit_i && mode0_i));
    end
  end

  assign addr_o = addr_reg;
  assign rw_o   = rw_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_dummy_read;
    @(posedge mclk_i) disable iff (reset_i)
    dummy_reg |-> (rw_reg && addr_reg == seq_pkg::ADDR_DUMMY);
  endproperty
  a_dummy_read: assert property (p_dummy_read) else $error("dummy cycle not read at ffff");

  property p_oe_internal;
    @(posedge mclk_i) disable iff (reset_i)
    (!data_oe_n_o && $past(rw_reg)) |-> $past(internal_hit_i && mode0_i);
  endproperty
  a_oe_internal: assert property (p_oe_internal) else $error("internal read driven out");

  property p_restart;
    @(posedge mclk_i) disable iff (reset_i)
    (e_tick && is_last) |=> (cyc_reg == seq_pkg::CYC_FIRST && role_reg == seq_pkg::R_OP
                             && addr_reg == $past(pc_next));
  endproperty
  a_restart: assert property (p_restart) else $error("no opcode fetch after last cycle");

  property p_swi_len;
    @(posedge mclk_i) disable iff (reset_i)
    (cyc_reg > 4'h1 && op_reg == seq_pkg::OP_SWI) |-> (last_cur == 4'hc);
  endproperty
  a_swi_len: assert property (p_swi_len) else $error("software interrupt length wrong");

  property p_st16_order;
    @(posedge mclk_i) disable iff (reset_i)
    (e_tick && kind_cur == seq_pkg::K_ST16 && cyc_reg == s_cur)
      |=> (!rw_reg && addr_reg == 16'($past(addr_reg) + 16'h1));
  endproperty
  a_st16_order: assert property (p_st16_order) else $error("16-bit store order wrong");

  property p_tst_no_write;
    @(posedge mclk_i) disable iff (reset_i)
    (e_tick && is_tst && cyc_next == 4'h6) |=> (rw_reg && dummy_reg);
  endproperty
  a_tst_no_write: assert property (p_tst_no_write) else $error("test wrote memory");

  property p_rmw_write;
    @(posedge mclk_i) disable iff (reset_i)
    (e_tick && kind_cur == seq_pkg::K_RMW && !is_tst && cyc_next == 4'h6)
      |=> (!rw_reg && addr_reg == ea_reg);
  endproperty
  a_rmw_write: assert property (p_rmw_write) else $error("write-back missing");

  property p_idx_dummy;
    @(posedge mclk_i) disable iff (reset_i)
    (e_tick && mode_cur == seq_pkg::M_IDX && cyc_next == 4'h3) |=> dummy_reg;
  endproperty
  a_idx_dummy: assert property (p_idx_dummy) else $error("indexed cycle 3 not dummy");

  property p_jsr_first;
    @(posedge mclk_i) disable iff (reset_i)
    (e_tick && kind_cur == seq_pkg::K_JSR && cyc_next == s_cur)
      |=> (rw_reg && addr_reg == ea_reg);
  endproperty
  a_jsr_first: assert property (p_jsr_first) else $error("call target not read first");

  property p_imm16;
    @(posedge mclk_i) disable iff (reset_i)
    (e_tick && mode_cur == seq_pkg::M_IMM && kind_cur == seq_pkg::K_LD16 && cyc_next == 4'h3)
      |=> (addr_reg == 16'(pc_reg + 16'h2));
  endproperty
  a_imm16: assert property (p_imm16) else $error("immediate low byte address wrong");

endmodule

// File: design/seq_pkg.sv
// package: constants, enumerations and decode helpers for the bus cycle sequencer
package seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 5;
  localparam int E_PERIOD_NS    = 1000;
  localparam int E_DIV          = E_PERIOD_NS / MCLK_PERIOD_NS;
  localparam logic [7:0] E_DIV_LAST = 8'(E_DIV - 1);
  localparam logic [7:0] E_DIV_HALF = 8'(E_DIV / 2);

  // ----------------------------------------------------------------
  // addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DUMMY   = 16'hffff;
  localparam logic [15:0] VEC_SWI_HI   = 16'hfffa;
  localparam logic [15:0] VEC_SWI_LO   = 16'hfffb;
  localparam logic [15:0] RESET_PC_DEF = 16'h0000;
  localparam logic [3:0]  CYC_FIRST    = 4'h1;

  // ----------------------------------------------------------------
  // opcodes with special sequences and their cycle counts
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MUL = 8'h3d;
  localparam logic [7:0] OP_SWI = 8'h3f;
  localparam logic [7:0] OP_WAI = 8'h3e;
  localparam logic [7:0] OP_RTI = 8'h3b;
  localparam logic [7:0] OP_RTS = 8'h39;
  localparam logic [3:0] CYC_MUL = 4'ha;
  localparam logic [3:0] CYC_SWI = 4'hc;
  localparam logic [3:0] CYC_WAI = 4'h9;
  localparam logic [3:0] CYC_RTI = 4'ha;
  localparam logic [3:0] CYC_RTS = 4'h5;
  localparam logic [3:0] CYC_REL = 4'h3;
  localparam logic [3:0] S_IMM   = 4'h2;
  localparam logic [3:0] S_DIR   = 4'h3;
  localparam logic [3:0] S_FAR   = 4'h4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {M_IMM, M_DIR, M_IDX, M_EXT, M_INH, M_REL} mode_t;
  typedef enum logic [3:0] {K_RD8, K_ST8, K_LD16, K_ST16, K_CMP16, K_RMW,
                            K_JMP, K_JSR, K_BSR, K_REL, K_INH} kind_t;
  typedef enum logic [2:0] {R_NONE, R_OP, R_AHI, R_ALO, R_DIR, R_OFF, R_REL,
                            R_DATA} role_t;

  // inherent instruction lengths
  function automatic logic [3:0] inh_len(input logic [7:0] op);
    case (op)
      OP_MUL, OP_RTI: inh_len = CYC_MUL;
      OP_SWI:         inh_len = CYC_SWI;
      OP_WAI:         inh_len = CYC_WAI;
      OP_RTS, 8'h38:  inh_len = CYC_RTS;
      8'h32, 8'h33, 8'h3c: inh_len = 4'h4;
      8'h3a, 8'h05, 8'h04, 8'h08, 8'h09, 8'h31, 8'h34, 8'h35, 8'h30, 8'h36,
      8'h37:          inh_len = 4'h3;
      default:        inh_len = 4'h2;
    endcase
  endfunction

endpackage

// File: tb/bus_memory_model.sv
// partner model: program memory sitting on the processor bus
module bus_memory_model (
  input  wire logic [15:0] addr_i,
  input  wire logic        rw_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // unused bytes hold a two-cycle no-op so a run past the program stays harmless
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // only the low address byte decodes, so the dummy address ffff just aliases
  // to a plain read with no side effect; while the processor writes, the
  // released bus shows the inverse of its byte, never a stale copy
  assign rdata_o = rw_i ? mem[addr_i[7:0]] : ~wdata_i;
endmodule

// File: tb/test_cpu_bus_cycle_sequencer.sv
// testbench: bus cycle traces of a short program, checked cycle by cycle
module test_cpu_bus_cycle_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        mode0_i = 1'b0;
  logic        internal_hit_i = 1'b0;
  logic        branch_taken = 1'b0;
  logic [7:0]  acc_a = 8'h3c, acc_b = 8'hc3, ccr = 8'h00, new_op = 8'h77, int_data = 8'h99;
  logic [15:0] index = 16'h00a0, stack = 16'h00f0;
  logic        rw_o, e_clk_o, data_oe_n_o;
  logic [7:0]  data_i, data_o;
  logic [15:0] addr_o;
  logic [7:0]  rd_data, opcode;
  logic        rd_strobe, instr_done;
  int          strobes = 0;
  int          dones = 0;
  int          fails = 0;
  int          cmp_count = 0;
  logic [25:0] trace_q[$];
  logic [24:0] exp_q[$];

  always #2.5 mclk_i = ~mclk_i;

  bus_cycle_sequencer DUT (
    .mclk_i(mclk_i), .reset_i(reset_i), .data_i(data_i), .mode0_i(mode0_i),
    .internal_hit_i(internal_hit_i), .internal_data_i(int_data), .acc_a_i(acc_a),
    .acc_b_i(acc_b), .index_i(index), .stack_i(stack), .ccr_i(ccr),
    .new_operand_i(new_op), .branch_taken_i(branch_taken), .e_clk_o(e_clk_o),
    .addr_o(addr_o), .rw_o(rw_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .rd_data_o(rd_data), .rd_strobe_o(rd_strobe), .opcode_o(opcode),
    .instr_done_o(instr_done)
  );

  // count the core-facing pulses, one per data read and one per instruction
  always @(posedge mclk_i) begin
    if (rd_strobe === 1'b1) strobes++;
    if (instr_done === 1'b1) dones++;
  end

  bus_memory_model mem_model (
    .addr_i(addr_o), .rw_i(rw_o), .wdata_i(data_o), .rdata_o(data_i)
  );

  // sample each bus cycle mid-period, long after address and data settled
  always @(posedge e_clk_o) begin
    #1;
    trace_q.push_back({addr_o, rw_o, data_o, data_oe_n_o});
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [25:0] want, input logic [25:0] got);
    cmp_count++;
    if (got !== want) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, want, got);
    end
  endtask

  // bytes go in most significant first, n bytes from the low end of b
  task automatic put(input logic [7:0] a, input logic [47:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      mem_model.mem[a + 8'(i)] = b[8 * (n - 1 - i) +: 8];
    end
  endtask

  task automatic seq(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({a + 16'(i), 1'b1, 8'h00});
    end
  endtask

  task automatic dum(input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({16'hffff, 1'b1, 8'h00});
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back({a, 1'b0, d});
  endtask

  // read data is the memory's business, so only writes compare the data byte;
  // the drive enable must follow the read/write level while nothing is internal
  task automatic check_cycles();
    logic [24:0] want;
    logic [25:0] got;
    int          n;
    while (exp_q.size() > 0) begin
      want = exp_q.pop_front();
      n = 0;
      while (trace_q.size() == 0 && n < 400) begin
        @(posedge mclk_i);
        n++;
      end
      if (trace_q.size() == 0) begin
        fails++;
        $display("mismatch bus cycle expected present seen none");
        exp_q.delete();
      end else begin
        got = trace_q.pop_front();
        cmp("bus cycle", {want[24:8], want[8] ? got[8:1] : want[7:0], want[8]}, got);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic immediate_ops();
    seq(16'h0000, 3);
    seq(16'h0003, 3);
    dum(1);
    check_cycles();
  endtask

  task automatic direct_ops();
    seq(16'h0006, 2);
    wr(16'h0040, 8'h3c);
    wr(16'h0041, 8'hc3);
    seq(16'h0008, 2);
    seq(16'h0050, 1);
    wr(16'h00f0, 8'h0a);
    wr(16'h00ef, 8'h00);
    check_cycles();
  endtask

  task automatic extended_ops();
    seq(16'h0050, 3);
    seq(16'h0060, 3);
    wr(16'h0044, 8'h3c);
    seq(16'h0063, 3);
    seq(16'h0045, 1);
    dum(1);
    wr(16'h0045, 8'h77);
    seq(16'h0066, 3);
    seq(16'h0045, 1);
    dum(2);
    check_cycles();
  endtask

  task automatic index_and_call_ops();
    seq(16'h0069, 2);
    dum(1);
    seq(16'h00a5, 2);
    seq(16'h006b, 3);
    seq(16'h0080, 1);
    wr(16'h00f0, 8'h6e);
    wr(16'h00ef, 8'h00);
    seq(16'h0080, 3);
    seq(16'h0090, 2);
    dum(1);
    seq(16'h0083, 2);
    dum(1);
    seq(16'h00a2, 1);
    seq(16'h0085, 2);
    dum(1);
    seq(16'h00a0, 1);
    wr(16'h00f0, 8'h87);
    wr(16'h00ef, 8'h00);
    check_cycles();
  endtask

  task automatic long_ops();
    seq(16'h00a0, 2);
    dum(8);
    seq(16'h00a1, 3);
    seq(16'h00c0, 2);
    check_cycles();
    @(posedge e_clk_o);
    #1;
    cmp("low data byte", 26'(8'ha5), 26'(rd_data));
    cmp("opcode", 26'(8'hfc), 26'(opcode));
    cmp("data reads", 26'(13), 26'(strobes));
    cmp("instructions done", 26'(15), 26'(dones));
  endtask

  // the no-ops fetched past the program read every cycle
  task automatic internal_reads();
    @(posedge mclk_i);
    internal_hit_i <= 1'b1;
    repeat (2) @(posedge e_clk_o);
    #1;
    cmp("drive enable", 26'(2'b11), 26'({rw_o, data_oe_n_o}));
    @(posedge mclk_i);
    mode0_i <= 1'b1;
    repeat (2) @(posedge e_clk_o);
    #1;
    cmp("mirrored read", 26'({2'b10, 8'h99}), 26'({rw_o, data_oe_n_o, data_o}));
  endtask

  // ----------------------------------------------------------------
  // sequence and closing
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // the whole program runs about eighty E-cycles of one microsecond
  initial begin
    #300us;
    fails++;
    end_of_test();
  end

  initial begin
    #1;
    put(8'h00, 48'hcc1234c30001, 6);
    put(8'h06, 48'hdd409d50, 4);
    put(8'h50, 48'h7e0060, 3);
    put(8'h60, 48'hb700447c0045, 6);
    put(8'h66, 48'h7d0045ee05bd, 6);
    put(8'h6c, 48'h0080, 2);
    put(8'h80, 48'hbc0090a602ad, 6);
    put(8'h86, 48'h00, 1);
    put(8'ha0, 48'h3dfc00c0, 4);
    put(8'hc0, 48'h5aa5, 2);
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    immediate_ops();
    direct_ops();
    extended_ops();
    index_and_call_ops();
    long_ops();
    internal_reads();
    end_of_test();
  end
endmodule
